// >>> design/irq_priority_ctrl.sv
// interrupt priority controller: pin filtering, pending flags, ranking, call sequencing
// Behaviour
// - external group 2 and 3 pending flags read 1 while pending, 0 otherwise.
// - group-4 channel flags set by hardware, cleared only by software write.
// - group-3 channel flags set by hardware, cleared only by software write.
// - accepted interrupt pushes program counter and loads source vector 0003H..0073H.
// - two priority bits per source give levels 0 (lowest) to 3 (highest).
// - only strictly higher level preempts; level 3 never preempted; higher wins.
// - equal levels resolved by fixed polling order, touch key first.
// - all interrupt flags sampled once per machine cycle on rising edge.
// - no vectoring during equal service, mid-instruction, or right after return/config.
// - requests cleared before the block ends are dropped; only valid ones polled.
// - hardware call saves only the program counter, never the status word.
// - return-from-interrupt clears in-service level; plain return leaves it set.
// - call decided by third cycle, call lasts seven cycles.
// - return-from-interrupt adds eight cycles before a call may begin.
// - group 2 single input; group 4 four inputs, group 3 three, one vector each.
// - trigger code 00 low level, 11 both edges.
// - code 01 falling edge, 10 rising edge; group-4 mode shared by channels.
// - edges need old level then new level held for the sample count.
// - edge-mode group 2/3 pending flag cleared when vectored.
// - low-level mode request follows pin and repeats while level persists.
// - sampling clock divided by 1, 16, 64 or 128 per group field.
// - sample count field needs 1 to 4 matching samples.
// - any enabled request wakes the processor from idle or power-down.
// - global enable bit gates every source; here it gates calls only, wake ignores it.
//
// The implementer's own choice: the Wishbone register port.
module irq_priority_ctrl #(
  parameter int CALL_LEN  = irq_ctrl_pkg::CALL_CYCLES,
  parameter int RETI_HOLD = irq_ctrl_pkg::RETI_WAIT
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  // register bus
  input  wire irq_ctrl_pkg::wb_req_t   wb_req,
  output irq_ctrl_pkg::wb_rsp_t        wb_rsp,
  // peripheral request flags, one per source in vector order
  input  wire logic [14:0]             periph_req,
  // external interrupt pins
  input  wire logic                    ext2_pin,
  input  wire logic [2:0]              ext3_pin,
  input  wire logic [3:0]              ext4_pin,
  // core instruction state
  input  wire logic                    core_last_cycle,
  input  wire logic                    core_is_reti,
  input  wire logic                    core_touch_cfg,
  // call request and status toward the core
  output irq_ctrl_pkg::call_req_t      call,
  output logic [3:0]                   in_service,
  output logic                         wake
);
  import irq_ctrl_pkg::*;

  if (CALL_LEN < 1 || CALL_LEN > 15 || RETI_HOLD < 1 || RETI_HOLD > 15) begin : g_check
    $error("call length and return hold must lie in 1..15");
  end

  typedef enum logic {ST_IDLE, ST_CALL} call_state_t;

  // configuration registers
  logic [7:0]  ext_sample_ctrl;
  logic [7:0]  prio_high_a;
  logic [7:0]  prio_high_b;
  logic [7:0]  prio_low_a;
  logic [7:0]  prio_low_b;
  logic [15:0] src_enable;
  logic [7:0]  ext_trigger_flag_reg;
  logic [2:0]  group3_channel_pending;
  logic [3:0]  group4_channel_pending;

  // bus decode
  wire         bus_req   = wb_req.cyc & wb_req.stb;
  wire         bus_wr    = bus_req & wb_req.we & wb_rsp.ack;
  wire [7:0]   bus_idx   = wb_req.adr[9:2];
  wire         wr_lo     = bus_wr & wb_req.sel[0];
  wire         wr_hi     = bus_wr & wb_req.sel[1];
  wire         wr_sample = wr_lo & (bus_idx == IDX_EXT_SAMPLE);
  wire         wr_pha    = wr_lo & (bus_idx == IDX_PRIO_HI_A);
  wire         wr_phb    = wr_lo & (bus_idx == IDX_PRIO_HI_B);
  wire         wr_pla    = wr_lo & (bus_idx == IDX_PRIO_LO_A);
  wire         wr_plb    = wr_lo & (bus_idx == IDX_PRIO_LO_B);
  wire         wr_g3     = wr_lo & (bus_idx == IDX_GROUP3);
  wire         wr_g4     = wr_lo & (bus_idx == IDX_GROUP4);
  wire         wr_trig   = wr_lo & (bus_idx == IDX_EXT_TRIG);
  wire         wr_en_lo  = wr_lo & (bus_idx == IDX_SRC_ENABLE);
  wire         wr_en_hi  = wr_hi & (bus_idx == IDX_SRC_ENABLE);
  wire [7:0]   wdat      = wb_req.dat[7:0];
  wire         cfg_write = wr_pha | wr_phb | wr_pla | wr_plb | wr_en_lo | wr_en_hi;

  // field extraction
  wire [1:0]   trig2     = ext_trigger_flag_reg[TRIG2_LSB +: 2];
  wire [1:0]   trig3     = ext_trigger_flag_reg[TRIG3_LSB +: 2];
  wire [1:0]   trig4     = ext_trigger_flag_reg[TRIG4_LSB +: 2];
  wire [1:0]   g23_div   = ext_sample_ctrl[G23_DIV_LSB +: 2];
  wire [1:0]   g23_cnt   = ext_sample_ctrl[G23_COUNT_LSB +: 2];
  wire [1:0]   g4_div    = ext_sample_ctrl[G4_DIV_LSB +: 2];
  wire [1:0]   g4_cnt    = ext_sample_ctrl[G4_COUNT_LSB +: 2];
  wire         global_irq_enable = src_enable[GLOBAL_EN_BIT];

  // register bus: ack one cycle after the request, dropped the cycle after
  logic [31:0] rdata;
  logic [7:0]  status;
  always_comb begin
    if (bus_idx == IDX_EXT_SAMPLE) rdata = {24'h0, ext_sample_ctrl};
    else if (bus_idx == IDX_PRIO_HI_A) rdata = {25'h0, prio_high_a[6:0]};
    else if (bus_idx == IDX_PRIO_HI_B) rdata = {24'h0, prio_high_b};
    else if (bus_idx == IDX_PRIO_LO_A) rdata = {25'h0, prio_low_a[6:0]};
    else if (bus_idx == IDX_PRIO_LO_B) rdata = {24'h0, prio_low_b};
    else if (bus_idx == IDX_GROUP3) rdata = {29'h0, group3_channel_pending};
    else if (bus_idx == IDX_GROUP4) rdata = {24'h0, group4_channel_pending[3:1], 4'h0, group4_channel_pending[0]};
    else if (bus_idx == IDX_EXT_TRIG) rdata = {24'h0, ext_trigger_flag_reg};
    else if (bus_idx == IDX_SRC_ENABLE) rdata = {16'h0, src_enable};
    else if (bus_idx == IDX_STATUS) rdata = {24'h0, status};
    else rdata = 32'h0;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= bus_req & ~wb_rsp.ack;
      wb_rsp.dat <= rdata;
    end
  end

  // configuration writes land on the acknowledging edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sample_ctrl <= RST_BYTE;
      prio_high_a     <= RST_BYTE;
      prio_high_b     <= RST_BYTE;
      prio_low_a      <= RST_BYTE;
      prio_low_b      <= RST_BYTE;
      src_enable      <= RST_ENABLE;
    end else begin
      if (wr_sample) ext_sample_ctrl <= wdat;
      if (wr_pha) prio_high_a <= {1'b0, wdat[6:0]};
      if (wr_phb) prio_high_b <= wdat;
      if (wr_pla) prio_low_a <= {1'b0, wdat[6:0]};
      if (wr_plb) prio_low_b <= wdat;
      if (wr_en_lo) src_enable[7:0] <= wdat;
      if (wr_en_hi) src_enable[15:8] <= wb_req.dat[15:8];
    end
  end

  // pin synchronisers; a change counts once stages two and three agree
  wire [NUM_PINS-1:0] pins = {ext4_pin, ext3_pin, ext2_pin};
  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic [NUM_PINS-1:0] sync3;
  logic [NUM_PINS-1:0] pin_level;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1     <= '1;
      sync2     <= '1;
      sync3     <= '1;
      pin_level <= '1;
    end else begin
      sync1     <= pins;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 ^ sync3));
    end
  end

  // shared prescaler; each group picks its own tick
  logic [6:0] presc;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) presc <= 7'h00;
    else presc <= presc + 7'h01;
  end

  function automatic logic div_tick(input logic [1:0] code, input logic [6:0] cnt);
    div_tick = (code == 2'h0) ? 1'b1 :
               (code == 2'h1) ? (cnt[3:0] == 4'h0) :
               (code == 2'h2) ? (cnt[5:0] == 6'h00) : (cnt == 7'h00);
  endfunction

  wire tick23 = div_tick(g23_div, presc);
  wire tick4  = div_tick(g4_div, presc);

  // per-pin sample filter and trigger detection
  logic [NUM_PINS-1:0] filt;
  logic [NUM_PINS-1:0] hit;
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    localparam bit IS_G4 = (i >= 4);
    logic [1:0] run;
    logic       filt_q;
    wire        tick = IS_G4 ? tick4 : tick23;
    wire [1:0]  need = IS_G4 ? g4_cnt : g23_cnt;
    wire [1:0]  mode = IS_G4 ? trig4 : ((i == 0) ? trig2 : trig3);
    wire        fall = filt_q & ~filt[i];
    wire        rise = ~filt_q & filt[i];
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        run     <= 2'h0;
        filt[i] <= 1'b1;
        filt_q  <= 1'b1;
      end else begin
        filt_q <= filt[i];
        if (tick && pin_level[i] != filt[i]) begin
          if (run >= need) begin
            filt[i] <= pin_level[i];
            run     <= 2'h0;
          end else begin
            run <= run + 2'h1;
          end
        end else if (tick) begin
          run <= 2'h0;
        end
      end
    end
    assign hit[i] = (mode == TRIG_LOW)  ? ~filt[i] :
                    (mode == TRIG_FALL) ? fall :
                    (mode == TRIG_RISE) ? rise : (fall | rise);
  end

  // ranking and call control signals
  logic [14:0] sampled;
  logic [3:0]  win_id;
  logic [1:0]  win_lvl;
  logic        win_valid;
  logic        hold_one;
  logic [3:0]  reti_wait;
  logic [3:0]  call_cnt;
  call_state_t state;

  wire         accept;
  wire         clr_ext2 = accept & (win_id == 4'(SRC_EXT2)) & (trig2 != TRIG_LOW);
  wire         clr_ext3 = accept & (win_id == 4'(SRC_EXT3)) & (trig3 != TRIG_LOW);

  // pending flags; hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_trigger_flag_reg   <= RST_BYTE;
      group3_channel_pending <= 3'h0;
      group4_channel_pending <= 4'h0;
    end else begin
      ext_trigger_flag_reg[7:2] <= wr_trig ? wdat[7:2] : ext_trigger_flag_reg[7:2];
      if (trig2 == TRIG_LOW) ext_trigger_flag_reg[EXT2_BIT] <= hit[0];
      else ext_trigger_flag_reg[EXT2_BIT] <=
        ((wr_trig ? wdat[EXT2_BIT] : ext_trigger_flag_reg[EXT2_BIT]) & ~clr_ext2) | hit[0];
      if (trig3 == TRIG_LOW) ext_trigger_flag_reg[EXT3_BIT] <= |hit[3:1];
      else ext_trigger_flag_reg[EXT3_BIT] <=
        ((wr_trig ? wdat[EXT3_BIT] : ext_trigger_flag_reg[EXT3_BIT]) & ~clr_ext3) | (|hit[3:1]);
      group3_channel_pending <= (wr_g3 ? wdat[2:0] : group3_channel_pending) | hit[3:1];
      group4_channel_pending <= (wr_g4 ? {wdat[7:5], wdat[0]} : group4_channel_pending) | hit[7:4];
    end
  end

  // merged group requests onto single vectors
  logic [14:0] src_flag;
  always_comb begin
    src_flag           = periph_req;
    src_flag[SRC_EXT2] = ext_trigger_flag_reg[EXT2_BIT];
    src_flag[SRC_EXT4] = |group4_channel_pending;
    src_flag[SRC_EXT3] = ext_trigger_flag_reg[EXT3_BIT];
  end

  wire [14:0] enabled   = src_flag & src_enable[14:0] & {15{global_irq_enable}};
  wire [14:0] prio_high = {prio_high_b, prio_high_a[6:0]};
  wire [14:0] prio_low  = {prio_low_b, prio_low_a[6:0]};

  // flags sampled every cycle; cleared ones drop out
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) sampled <= 15'h0000;
    else sampled <= enabled;
  end

  // highest level wins; strict compare keeps lower index on ties
  always_comb begin
    win_valid = 1'b0;
    win_id    = 4'h0;
    win_lvl   = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (sampled[i] && (!win_valid || {prio_high[i], prio_low[i]} > win_lvl)) begin
        win_valid = 1'b1;
        win_id    = 4'(i);
        win_lvl   = {prio_high[i], prio_low[i]};
      end
    end
  end

  // level currently in service, highest bit first
  wire       act_valid = |in_service;
  wire [1:0] act_lvl   = in_service[3] ? 2'h3 : in_service[2] ? 2'h2 : in_service[1] ? 2'h1 : 2'h0;
  wire       preempt_ok = !act_valid || (win_lvl > act_lvl);
  wire       blocked = hold_one || (reti_wait != 4'h0) || core_is_reti || core_touch_cfg || cfg_write;
  assign accept = (state == ST_IDLE) && core_last_cycle && win_valid && preempt_ok && !blocked;

  // one more instruction and return wait
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_one  <= 1'b0;
      reti_wait <= 4'h0;
    end else begin
      if (core_is_reti || core_touch_cfg || cfg_write) hold_one <= 1'b1;
      else if (core_last_cycle) hold_one <= 1'b0;
      if (core_is_reti && !core_last_cycle) reti_wait <= 4'(RETI_HOLD);
      else if (reti_wait != 4'h0) reti_wait <= reti_wait - 4'h1;
    end
  end

  // in-service bookkeeping; a plain return never touches it
  logic [3:0] top_bit;
  assign top_bit = 4'h1 << act_lvl;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) in_service <= 4'h0;
    else if (accept) in_service <= in_service | (4'h1 << win_lvl);
    else if (core_is_reti && core_last_cycle) in_service <= in_service & ~top_bit;
  end

  // call sequence: vector out, core pushes the program counter only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      call_cnt <= 4'h0;
      call     <= '0;
    end else begin
      call.start <= accept;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            state       <= ST_CALL;
            call_cnt    <= 4'(CALL_LEN - 1);
            call.busy   <= 1'b1;
            call.vector <= VECTOR_BASE + (16'(win_id) << VECTOR_SHIFT);
            call.level  <= win_lvl;
          end
        end
        ST_CALL: begin
          if (call_cnt == 4'h0) begin
            state     <= ST_IDLE;
            call.busy <= 1'b0;
          end else begin
            call_cnt <= call_cnt - 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // wake ignores the global gate so a sleeping core always resumes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) wake <= 1'b0;
    else wake <= |(src_flag & src_enable[14:0]);
  end

  // status word for software
  assign status = {2'h0, blocked, call.busy, in_service};

endmodule : irq_priority_ctrl

// >>> design/irq_ctrl_pkg.sv
// constants, register map and carrier types for the interrupt priority controller
package irq_ctrl_pkg;

  // source count and fixed source positions in vector order
  localparam int          NUM_SRC        = 15;
  localparam int          NUM_PINS       = 8;
  localparam int          SRC_EXT2       = 8;
  localparam int          SRC_EXT4       = 9;
  localparam int          SRC_EXT3       = 13;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_EXT_SAMPLE = 8'hA4;
  localparam logic [7:0]  IDX_PRIO_HI_A  = 8'hB4;
  localparam logic [7:0]  IDX_PRIO_HI_B  = 8'hB5;
  localparam logic [7:0]  IDX_PRIO_LO_A  = 8'hB8;
  localparam logic [7:0]  IDX_PRIO_LO_B  = 8'hB9;
  localparam logic [7:0]  IDX_GROUP3     = 8'hD1;
  localparam logic [7:0]  IDX_GROUP4     = 8'hD8;
  localparam logic [7:0]  IDX_EXT_TRIG   = 8'hE8;
  localparam logic [7:0]  IDX_SRC_ENABLE = 8'hF0;
  localparam logic [7:0]  IDX_STATUS     = 8'hF1;

  // reset values
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_ENABLE     = 16'h0000;

  // field positions
  localparam int          EXT2_BIT       = 0;
  localparam int          EXT3_BIT       = 1;
  localparam int          TRIG2_LSB      = 2;
  localparam int          TRIG3_LSB      = 4;
  localparam int          TRIG4_LSB      = 6;
  localparam int          G23_COUNT_LSB  = 0;
  localparam int          G23_DIV_LSB    = 2;
  localparam int          G4_COUNT_LSB   = 4;
  localparam int          G4_DIV_LSB     = 6;
  localparam int          GLOBAL_EN_BIT  = 15;

  // trigger mode codes
  localparam logic [1:0]  TRIG_LOW       = 2'h0;
  localparam logic [1:0]  TRIG_FALL      = 2'h1;
  localparam logic [1:0]  TRIG_RISE      = 2'h2;
  localparam logic [1:0]  TRIG_BOTH      = 2'h3;

  // vector table and timing in machine cycles (one clock each)
  localparam logic [15:0] VECTOR_BASE    = 16'h0003;
  localparam int          VECTOR_SHIFT   = 3;
  localparam int          CALL_CYCLES    = 7;
  localparam int          RETI_WAIT      = 8;

  // classic wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // call request handed to the core
  typedef struct packed {
    logic        start;
    logic        busy;
    logic [15:0] vector;
    logic [1:0]  level;
  } call_req_t;

endpackage : irq_ctrl_pkg

// >>> sim/irq_ctrl_checker.sv
// port assertions for the interrupt priority controller
module irq_ctrl_checker #(
  parameter int CALL_LEN = 7
) (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    reset_n,
  // register bus
  input wire irq_ctrl_pkg::wb_req_t   wb_req,
  input wire irq_ctrl_pkg::wb_rsp_t   wb_rsp,
  // core side
  input wire logic                    core_last_cycle,
  input wire logic                    core_is_reti,
  input wire logic                    core_touch_cfg,
  input wire irq_ctrl_pkg::call_req_t call,
  input wire logic [3:0]              in_service
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // busy run length; a counter keeps long calls cheap
  logic [4:0] busy_len;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busy_len <= 5'h00;
    else if (call.busy) busy_len <= busy_len + 5'h01;
    else busy_len <= 5'h00;
  end

  // named steps
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence s_quiet8;
    !call.start [*8];
  endsequence

  property p_ack_one;
    s_req |=> wb_rsp.ack ##1 !wb_rsp.ack;
  endproperty
  property p_vector;
    call.start |-> call.vector[2:0] == 3'h3 && call.vector <= 16'h0073;
  endproperty
  property p_above;
    call.start |-> ($past(in_service) >> call.level) == 4'h0;
  endproperty
  property p_marks;
    call.start |-> ##[0:1] in_service[call.level];
  endproperty
  property p_reti;
    core_is_reti && core_last_cycle && in_service != 4'h0 |=> $countones(in_service) < $countones($past(in_service));
  endproperty
  property p_final;
    call.start |-> $past(core_last_cycle);
  endproperty
  property p_hold;
    (core_touch_cfg || core_is_reti) && core_last_cycle |=> !call.start;
  endproperty
  property p_reti_wait;
    $rose(core_is_reti) && !core_last_cycle |=> s_quiet8;
  endproperty
  property p_busy_len;
    $fell(call.busy) |-> busy_len == CALL_LEN;
  endproperty
  property p_busy_start;
    $rose(call.busy) |-> call.start;
  endproperty

  a_ack_one: assert property (p_ack_one) else $error("bus ack not a lone pulse after request");
  a_vector: assert property (p_vector) else $error("vector off the table");
  a_above: assert property (p_above) else $error("call at or below level in service");
  a_marks: assert property (p_marks) else $error("called level not marked in service");
  a_reti: assert property (p_reti) else $error("return did not clear a level");
  a_final: assert property (p_final) else $error("call outside final cycle");
  a_hold: assert property (p_hold) else $error("call right after return or config");
  a_reti_wait: assert property (p_reti_wait) else $error("call within return wait");
  a_busy_len: assert property (p_busy_len) else $error("call length wrong");
  a_busy_start: assert property (p_busy_start) else $error("busy without start");
endmodule : irq_ctrl_checker

bind irq_priority_ctrl irq_ctrl_checker #(.CALL_LEN(CALL_LEN)) u_irq_ctrl_checker (
  .mclk(mclk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .core_last_cycle(core_last_cycle),
  .core_is_reti(core_is_reti), .core_touch_cfg(core_touch_cfg), .call(call), .in_service(in_service));

// >>> sim/core_model.sv
// behavioural core: instruction boundaries and returns
module core_model (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  // instruction shape chosen by the bench
  input  wire logic [4:0]              instr_len,
  input  wire logic                    next_reti,
  input  wire logic                    next_cfg,
  // hardware call from the controller
  input  wire irq_ctrl_pkg::call_req_t call,
  // instruction state toward the controller
  output logic                         core_last_cycle,
  output logic                         core_is_reti,
  output logic                         core_touch_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  logic [4:0] step;
  // no final cycle while the call owns the core
  assign core_last_cycle = !call.busy && (step + 5'h01 >= instr_len);
  // the call replaces the pending instruction
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      step           <= 5'h00;
      core_is_reti   <= 1'b0;
      core_touch_cfg <= 1'b0;
    end else if (call.busy || core_last_cycle) begin
      step           <= 5'h00;
      core_is_reti   <= next_reti && !call.busy;
      core_touch_cfg <= next_cfg && !call.busy;
    end else begin
      step <= step + 5'h01;
    end
  end
endmodule : core_model

// >>> sim/testbench.sv
// self-checking bench for the interrupt priority controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  logic        mclk, reset_n, e2, wake, last, reti, cfg, nreti, ncfg;
  logic [2:0]  e3;
  logic [3:0]  e4, insvc;
  logic [4:0]  ilen;
  logic [14:0] periph;
  logic [31:0] q;
  wb_req_t     req;
  wb_rsp_t     rsp;
  call_req_t   call;
  int          n_errors, total_checks, k, i, m;
  logic [3:0]  fall_tab = 4'hB;
  logic [3:0]  rise_tab = 4'hC;
  logic [7:0]  regs [8] = '{IDX_EXT_SAMPLE, IDX_PRIO_HI_A, IDX_PRIO_HI_B, IDX_PRIO_LO_A,
                            IDX_PRIO_LO_B, IDX_GROUP3, IDX_GROUP4, 8'h10};

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  irq_priority_ctrl u_irq_priority_ctrl (.mclk(mclk), .reset_n(reset_n), .wb_req(req), .wb_rsp(rsp),
    .periph_req(periph), .ext2_pin(e2), .ext3_pin(e3), .ext4_pin(e4), .core_last_cycle(last),
    .core_is_reti(reti), .core_touch_cfg(cfg), .call(call), .in_service(insvc), .wake(wake));
  core_model u_core_model (.mclk(mclk), .reset_n(reset_n), .instr_len(ilen), .next_reti(nreti),
    .next_cfg(ncfg), .call(call), .core_last_cycle(last), .core_is_reti(reti), .core_touch_cfg(cfg));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; waits for ack, the watchdog ends a hang
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [15:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b1, wr, {idx, 2'b00}, 4'hF, {16'h0000, d}};
    do @(posedge mclk); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 16'h0000);
    check(q, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic quiet(input int n);
    k = 0;
    repeat (n) begin
      @(posedge mclk);
      if (call.start === 1'b1) k++;
    end
    check(k, 0);
  endtask : quiet

  task automatic take(input logic [15:0] vec, input logic [3:0] svc);
    for (k = 0; k < 200 && call.start !== 1'b1; k++) @(posedge mclk);
    check({k < 200, call.vector}, {1'b1, vec});
    idle(2);
    check(insvc, svc);
  endtask : take

  // slow return so the core shows it before its final cycle
  task automatic do_reti(input logic [3:0] svc);
    ilen  <= 5'h03;
    nreti <= 1'b1;
    for (k = 0; k < 100 && reti !== 1'b1; k++) @(posedge mclk);
    nreti <= 1'b0;
    for (k = 0; k < 100 && reti === 1'b1; k++) @(posedge mclk);
    ilen  <= 5'h01;
    idle(2);
    check(insvc, svc);
  endtask : do_reti

  task automatic give_verdict;
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict;
  end

  initial begin
    reset_n = 1'b0;
    req     = '0;
    periph  = '0;
    e2      = 1'b1;
    e3      = 3'h7;
    e4      = 4'hF;
    ilen    = 5'h01;
    nreti   = 1'b0;
    ncfg    = 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    // register table, then an unmapped index
    for (i = 0; i < 8; i++) begin
      rd(regs[i], 32'h0);
    end
    for (i = 0; i < 5; i++) begin
      bus(regs[i], 1'b1, 16'h005A);
      rd(regs[i], 32'h5A);
      bus(regs[i], 1'b1, 16'h0000);
    end
    bus(8'h10, 1'b1, 16'h00FF);
    rd(8'h10, 32'h0);
    // two equal sources, global gate closed first
    bus(IDX_SRC_ENABLE, 1'b1, 16'h7FFF);
    periph <= 15'h0003;
    idle(8);
    check(wake, 1'b1);
    quiet(20);
    bus(IDX_SRC_ENABLE, 1'b1, 16'hFFFF);
    take(16'h0003, 4'h1);
    // equal level waits and is dropped while blocked
    periph <= 15'h0006;
    quiet(20);
    periph <= 15'h0000;
    bus(IDX_PRIO_HI_A, 1'b1, 16'h0002);
    bus(IDX_PRIO_LO_A, 1'b1, 16'h0002);
    // config instructions hold the call off until a plain one completes
    ncfg   <= 1'b1;
    periph <= 15'h0002;
    quiet(20);
    ncfg   <= 1'b0;
    take(16'h000B, 4'h9);
    periph <= 15'h0000;
    do_reti(4'h1);
    do_reti(4'h0);
    quiet(30);
    check(wake, 1'b0);
    // every trigger mode on a fall, then a rise
    bus(IDX_SRC_ENABLE, 1'b1, 16'h0000);
    for (m = 0; m < 4; m++) begin
      bus(IDX_EXT_TRIG, 1'b1, {12'h000, m[1:0], 2'b00});
      e2 <= 1'b0;
      idle(12);
      rd(IDX_EXT_TRIG, {28'h0, m[1:0], 1'b0, fall_tab[m]});
      bus(IDX_EXT_TRIG, 1'b1, {12'h000, m[1:0], 2'b00});
      e2 <= 1'b1;
      idle(12);
      rd(IDX_EXT_TRIG, {28'h0, m[1:0], 1'b0, rise_tab[m]});
    end
    // short glitch at slow sampling is filtered out
    bus(IDX_EXT_SAMPLE, 1'b1, 16'h0007);
    bus(IDX_EXT_TRIG, 1'b1, 16'h0004);
    e2 <= 1'b0;
    idle(40);
    e2 <= 1'b1;
    idle(120);
    rd(IDX_EXT_TRIG, 32'h4);
    e2 <= 1'b0;
    idle(120);
    rd(IDX_EXT_TRIG, 32'h5);
    e2 <= 1'b1;
    idle(120);
    bus(IDX_EXT_SAMPLE, 1'b1, 16'h0000);
    // merged groups keep channel flags until cleared
    bus(IDX_EXT_TRIG, 1'b1, 16'h0050);
    e4 <= 4'h0;
    e3 <= 3'h0;
    idle(12);
    e4 <= 4'hF;
    e3 <= 3'h7;
    idle(12);
    rd(IDX_GROUP4, 32'hE1);
    rd(IDX_GROUP3, 32'h7);
    rd(IDX_EXT_TRIG, 32'h52);
    bus(IDX_GROUP4, 1'b1, 16'h0000);
    bus(IDX_GROUP3, 1'b1, 16'h0000);
    rd(IDX_GROUP4, 32'h0);
    rd(IDX_GROUP3, 32'h0);
    // edge request cleared on vectoring
    bus(IDX_EXT_TRIG, 1'b1, 16'h0004);
    bus(IDX_SRC_ENABLE, 1'b1, 16'h8100);
    e2 <= 1'b0;
    take(16'h0043, 4'h1);
    rd(IDX_EXT_TRIG, 32'h4);
    e2 <= 1'b1;
    do_reti(4'h0);
    give_verdict;
  end
endmodule : testbench
